// file: irq_flag_enable_controller.sv
// irq_flag_enable_controller: request flags, enables, global enable and
// external pin edge detect; offers one vector to the core at a time.
// assumes event inputs are one-cycle pulses on CLK_IN; pin is async.
//
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
module irq_flag_enable_controller #(
  parameter int unsigned SYNC_STAGES = 3
) (
  input wire logic CLK_IN, // system clock, 10 MHz
  input wire logic RST_IN, // synchronous reset, active high
  input wire logic [3:0] WB_ADR_IN, // wishbone byte address
  input wire logic [31:0] WB_DAT_IN, // wishbone write data
  input wire logic [3:0] WB_SEL_IN, // wishbone byte selects
  input wire logic WB_WE_IN, // wishbone write enable
  input wire logic WB_CYC_IN, // wishbone cycle
  input wire logic WB_STB_IN, // wishbone strobe
  output logic [31:0] WB_DAT_OUT, // wishbone read data
  output logic WB_ACK_OUT, // wishbone acknowledge
  input wire logic EXT_PIN_IN, // external interrupt pin, async
  input wire logic LOW_SUPPLY_EV_IN, // low supply detector event
  input wire logic SERIAL_EV_IN, // serial module event
  input wire logic CONVERTER_EV_IN, // conversion done event
  input wire logic EEPROM_EV_IN, // eeprom write done event
  input wire logic MATCH_P_EV_IN, // timer comparator p match
  input wire logic MATCH_A_EV_IN, // timer comparator a match
  input wire logic TICK0_EV_IN, // time base 0 event
  input wire logic TICK1_EV_IN, // time base 1 event
  input wire logic STACK_FULL_IN, // core return stack full
  input wire logic IRQ_TAKE_IN, // core accepts offered vector, pulse
  output logic IRQ_REQ_OUT, // request to core, level
  output logic [3:0] IRQ_VEC_OUT, // offered source id
  output logic WAKE_OUT // some flag is set
);
  // fewer stages let a metastable sample reach the edge detector
  if (SYNC_STAGES < 3) begin : g_sync_check
    $error("SYNC_STAGES must be at least 3");
  end
  if (irq_ctrl_pkg::NSRC > 16) begin : g_src_check
    $error("source ids must fit the 4-bit vector port");
  end

  localparam int unsigned N = irq_ctrl_pkg::NSRC;
  localparam int unsigned S2 = SYNC_STAGES - 2;
  localparam int unsigned S3 = SYNC_STAGES - 1;

  typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} bus_state_t;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a[3:2] == ofs[3:2]);
  endfunction : hit

  // pin synchroniser; s0 feeds only s1; lvl moves once pin_q[S2] and pin_q[S3], the last two stages, agree
  logic [SYNC_STAGES-1:0] pin_q, pin_d;
  logic lvl_q, lvl_d;
  logic [1:0] edge_q, edge_d;
  logic glob_q, glob_d;
  logic [N-1:0] flag_q, flag_d, on_q, on_d;
  bus_state_t bus_q, bus_d;
  logic [31:0] rdat_q, rdat_d;
  logic [3:0] vec_q, vec_d;
  logic req_q, req_d;
  logic wr, pin_hit;
  logic [7:0] wbyte;
  logic [N-1:0] ev, ready;

  assign wr = WB_CYC_IN && WB_STB_IN && WB_WE_IN && WB_SEL_IN[0]
              && bus_q == BUS_IDLE;
  assign wbyte = WB_DAT_IN[7:0];

  always_comb begin
    lvl_d = (pin_q[S2] == pin_q[S3]) ? pin_q[S3] : lvl_q;
    pin_hit = 1'b0;
    case (edge_q)
      irq_ctrl_pkg::EDGE_RISE: pin_hit = lvl_d && !lvl_q;
      irq_ctrl_pkg::EDGE_FALL: pin_hit = !lvl_d && lvl_q;
      irq_ctrl_pkg::EDGE_BOTH: pin_hit = lvl_d != lvl_q;
      default: pin_hit = 1'b0;
    endcase
  end

  always_comb begin
    ev = '0;
    ev[irq_ctrl_pkg::SRC_EXT] = pin_hit;
    ev[irq_ctrl_pkg::SRC_LOW] = LOW_SUPPLY_EV_IN;
    ev[irq_ctrl_pkg::SRC_SER] = SERIAL_EV_IN;
    ev[irq_ctrl_pkg::SRC_CONV] = CONVERTER_EV_IN;
    ev[irq_ctrl_pkg::SRC_TMP] = MATCH_P_EV_IN;
    ev[irq_ctrl_pkg::SRC_TMA] = MATCH_A_EV_IN;
    ev[irq_ctrl_pkg::SRC_EEP] = EEPROM_EV_IN;
    ev[irq_ctrl_pkg::SRC_TB0] = TICK0_EV_IN;
    ev[irq_ctrl_pkg::SRC_TB1] = TICK1_EV_IN;
  end

  assign ready = flag_d & on_d;

  // register writes, then service clear, then hardware set wins
  always_comb begin
    pin_d = {pin_q[S2:0], EXT_PIN_IN};
    edge_d = edge_q;
    glob_d = glob_q;
    flag_d = flag_q;
    on_d = on_q;
    if (wr && hit(WB_ADR_IN, irq_ctrl_pkg::OFS_EDGE)) begin
      edge_d = wbyte[1:0];
    end
    if (wr && hit(WB_ADR_IN, irq_ctrl_pkg::OFS_CTL0)) begin
      glob_d = wbyte[irq_ctrl_pkg::C0_GLOBAL];
      on_d[irq_ctrl_pkg::SRC_EXT] = wbyte[irq_ctrl_pkg::C0_EXT_ON];
      on_d[irq_ctrl_pkg::SRC_SER] = wbyte[irq_ctrl_pkg::C0_SER_ON];
      on_d[irq_ctrl_pkg::SRC_LOW] = wbyte[irq_ctrl_pkg::C0_LOW_ON];
      flag_d[irq_ctrl_pkg::SRC_EXT] = wbyte[irq_ctrl_pkg::C0_EXT_F];
      flag_d[irq_ctrl_pkg::SRC_SER] = wbyte[irq_ctrl_pkg::C0_SER_F];
      flag_d[irq_ctrl_pkg::SRC_LOW] = wbyte[irq_ctrl_pkg::C0_LOW_F];
    end
    if (wr && hit(WB_ADR_IN, irq_ctrl_pkg::OFS_CTL1)) begin
      on_d[irq_ctrl_pkg::SRC_CONV] = wbyte[irq_ctrl_pkg::C1_CONV_ON];
      on_d[irq_ctrl_pkg::SRC_EEP] = wbyte[irq_ctrl_pkg::C1_EEP_ON];
      on_d[irq_ctrl_pkg::SRC_TMP] = wbyte[irq_ctrl_pkg::C1_TMP_ON];
      on_d[irq_ctrl_pkg::SRC_TMA] = wbyte[irq_ctrl_pkg::C1_TMA_ON];
      flag_d[irq_ctrl_pkg::SRC_CONV] = wbyte[irq_ctrl_pkg::C1_CONV_F];
      flag_d[irq_ctrl_pkg::SRC_EEP] = wbyte[irq_ctrl_pkg::C1_EEP_F];
      flag_d[irq_ctrl_pkg::SRC_TMP] = wbyte[irq_ctrl_pkg::C1_TMP_F];
      flag_d[irq_ctrl_pkg::SRC_TMA] = wbyte[irq_ctrl_pkg::C1_TMA_F];
    end
    if (wr && hit(WB_ADR_IN, irq_ctrl_pkg::OFS_CTL2)) begin
      on_d[irq_ctrl_pkg::SRC_TB0] = wbyte[irq_ctrl_pkg::C2_TB0_ON];
      on_d[irq_ctrl_pkg::SRC_TB1] = wbyte[irq_ctrl_pkg::C2_TB1_ON];
      flag_d[irq_ctrl_pkg::SRC_TB0] = wbyte[irq_ctrl_pkg::C2_TB0_F];
      flag_d[irq_ctrl_pkg::SRC_TB1] = wbyte[irq_ctrl_pkg::C2_TB1_F];
    end
    if (req_q && IRQ_TAKE_IN) begin
      flag_d[vec_q] = 1'b0;
      glob_d = 1'b0;
    end
    flag_d = flag_d | ev;
  end

  // offer lowest pending id; a lower id that becomes ready replaces the one offered
  always_comb begin
    vec_d = vec_q;
    req_d = 1'b0;
    if (glob_d && !STACK_FULL_IN) begin
      for (int i = N - 1; i >= 0; i--) begin
        if (ready[i]) begin
          vec_d = 4'(i);
          req_d = 1'b1;
        end
      end
    end
  end

  always_comb begin
    bus_d = BUS_IDLE;
    rdat_d = rdat_q;
    if (bus_q == BUS_IDLE && WB_CYC_IN && WB_STB_IN) begin
      bus_d = BUS_ACK;
      rdat_d = '0; // unmapped and reserved read zero
      if (hit(WB_ADR_IN, irq_ctrl_pkg::OFS_EDGE)) begin
        rdat_d[1:0] = edge_q;
      end
      if (hit(WB_ADR_IN, irq_ctrl_pkg::OFS_CTL0)) begin
        rdat_d[irq_ctrl_pkg::C0_GLOBAL] = glob_q;
        rdat_d[irq_ctrl_pkg::C0_EXT_ON] = on_q[irq_ctrl_pkg::SRC_EXT];
        rdat_d[irq_ctrl_pkg::C0_SER_ON] = on_q[irq_ctrl_pkg::SRC_SER];
        rdat_d[irq_ctrl_pkg::C0_LOW_ON] = on_q[irq_ctrl_pkg::SRC_LOW];
        rdat_d[irq_ctrl_pkg::C0_EXT_F] = flag_q[irq_ctrl_pkg::SRC_EXT];
        rdat_d[irq_ctrl_pkg::C0_SER_F] = flag_q[irq_ctrl_pkg::SRC_SER];
        rdat_d[irq_ctrl_pkg::C0_LOW_F] = flag_q[irq_ctrl_pkg::SRC_LOW];
      end
      if (hit(WB_ADR_IN, irq_ctrl_pkg::OFS_CTL1)) begin
        rdat_d[irq_ctrl_pkg::C1_CONV_ON] = on_q[irq_ctrl_pkg::SRC_CONV];
        rdat_d[irq_ctrl_pkg::C1_EEP_ON] = on_q[irq_ctrl_pkg::SRC_EEP];
        rdat_d[irq_ctrl_pkg::C1_TMP_ON] = on_q[irq_ctrl_pkg::SRC_TMP];
        rdat_d[irq_ctrl_pkg::C1_TMA_ON] = on_q[irq_ctrl_pkg::SRC_TMA];
        rdat_d[irq_ctrl_pkg::C1_CONV_F] = flag_q[irq_ctrl_pkg::SRC_CONV];
        rdat_d[irq_ctrl_pkg::C1_EEP_F] = flag_q[irq_ctrl_pkg::SRC_EEP];
        rdat_d[irq_ctrl_pkg::C1_TMP_F] = flag_q[irq_ctrl_pkg::SRC_TMP];
        rdat_d[irq_ctrl_pkg::C1_TMA_F] = flag_q[irq_ctrl_pkg::SRC_TMA];
      end
      if (hit(WB_ADR_IN, irq_ctrl_pkg::OFS_CTL2)) begin
        rdat_d[irq_ctrl_pkg::C2_TB0_ON] = on_q[irq_ctrl_pkg::SRC_TB0];
        rdat_d[irq_ctrl_pkg::C2_TB1_ON] = on_q[irq_ctrl_pkg::SRC_TB1];
        rdat_d[irq_ctrl_pkg::C2_TB0_F] = flag_q[irq_ctrl_pkg::SRC_TB0];
        rdat_d[irq_ctrl_pkg::C2_TB1_F] = flag_q[irq_ctrl_pkg::SRC_TB1];
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      pin_q <= '0;
      lvl_q <= 1'b0;
      edge_q <= irq_ctrl_pkg::EDGE_OFF;
      glob_q <= 1'b0;
      flag_q <= irq_ctrl_pkg::NSRC_RST;
      on_q <= irq_ctrl_pkg::NSRC_RST;
      bus_q <= BUS_IDLE;
      rdat_q <= 32'h0000_0000;
      vec_q <= 4'h0;
      req_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
      lvl_q <= lvl_d;
      edge_q <= edge_d;
      glob_q <= glob_d;
      flag_q <= flag_d;
      on_q <= on_d;
      bus_q <= bus_d;
      rdat_q <= rdat_d;
      vec_q <= vec_d;
      req_q <= req_d;
    end
  end

  assign WB_ACK_OUT = (bus_q == BUS_ACK);
  assign WB_DAT_OUT = rdat_q;
  assign IRQ_REQ_OUT = req_q;
  assign IRQ_VEC_OUT = vec_q;
  assign WAKE_OUT = |flag_q;

  req_gated_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    IRQ_REQ_OUT |-> glob_q && flag_q[vec_q] && on_q[vec_q])
    else $error("request without enable");
  req_holds_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    IRQ_REQ_OUT && !IRQ_TAKE_IN && !wr && !STACK_FULL_IN |=> IRQ_REQ_OUT)
    else $error("pending request dropped");
  take_clears_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    IRQ_REQ_OUT && IRQ_TAKE_IN && !wr |=> !glob_q)
    else $error("global not cleared on take");
  take_flag_clr_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    IRQ_REQ_OUT && IRQ_TAKE_IN && !wr && !ev[vec_q]
    |=> !flag_q[$past(vec_q)])
    else $error("flag not cleared on take");
  stack_full_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    STACK_FULL_IN |=> !IRQ_REQ_OUT)
    else $error("request while stack full");
  wake_flag_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    $rose(flag_q[irq_ctrl_pkg::SRC_TB1]) |-> WAKE_OUT)
    else $error("no wake on flag");
  event_sets_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    TICK0_EV_IN |=> flag_q[irq_ctrl_pkg::SRC_TB0])
    else $error("event lost");
  rise_edge_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    edge_q == irq_ctrl_pkg::EDGE_RISE && pin_q[S2] && pin_q[S3] && !lvl_q
    |=> flag_q[irq_ctrl_pkg::SRC_EXT])
    else $error("rising edge missed");
  fall_edge_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    edge_q == irq_ctrl_pkg::EDGE_FALL && !pin_q[S2] && !pin_q[S3] && lvl_q
    |=> flag_q[irq_ctrl_pkg::SRC_EXT])
    else $error("falling edge missed");
  both_edge_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    edge_q == irq_ctrl_pkg::EDGE_BOTH && pin_q[S2] == pin_q[S3]
    && pin_q[S3] != lvl_q |=> flag_q[irq_ctrl_pkg::SRC_EXT])
    else $error("pin edge missed in both mode");
  edge_off_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    edge_q == irq_ctrl_pkg::EDGE_OFF && !wr
    && !flag_q[irq_ctrl_pkg::SRC_EXT] |=> !flag_q[irq_ctrl_pkg::SRC_EXT])
    else $error("pin flag set while off");
  prio_order_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    IRQ_REQ_OUT && vec_q != irq_ctrl_pkg::SRC_EXT
    |-> !(flag_q[irq_ctrl_pkg::SRC_EXT] && on_q[irq_ctrl_pkg::SRC_EXT]))
    else $error("priority broken");
  ack_once_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    WB_CYC_IN && WB_STB_IN && bus_q == BUS_IDLE |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
    else $error("ack timing");
  high_zero_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    WB_ACK_OUT |-> WB_DAT_OUT[31:8] == 24'h00_0000)
    else $error("read data above the low byte");
  edge_rsvd_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    WB_ACK_OUT && hit(WB_ADR_IN, irq_ctrl_pkg::OFS_EDGE)
    |-> WB_DAT_OUT[7:2] == 6'h00)
    else $error("edge register reserved bits set");
  ctl0_rsvd_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    WB_ACK_OUT && hit(WB_ADR_IN, irq_ctrl_pkg::OFS_CTL0)
    |-> !WB_DAT_OUT[7])
    else $error("control 0 bit 7 set");
  ctl2_rsvd_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    WB_ACK_OUT && hit(WB_ADR_IN, irq_ctrl_pkg::OFS_CTL2)
    |-> WB_DAT_OUT[3:2] == 2'h0 && WB_DAT_OUT[7:6] == 2'h0)
    else $error("time base register reserved bits set");
  edge_write_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    wr && hit(WB_ADR_IN, irq_ctrl_pkg::OFS_EDGE)
    |=> edge_q == $past(WB_DAT_IN[1:0]))
    else $error("edge field write lost");
  on_write_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    wr && hit(WB_ADR_IN, irq_ctrl_pkg::OFS_CTL2)
    |=> on_q[irq_ctrl_pkg::SRC_TB0]
    == $past(WB_DAT_IN[irq_ctrl_pkg::C2_TB0_ON]))
    else $error("enable write lost");
  glob_write_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    wr && hit(WB_ADR_IN, irq_ctrl_pkg::OFS_CTL0) && !IRQ_TAKE_IN
    |=> glob_q == $past(WB_DAT_IN[irq_ctrl_pkg::C0_GLOBAL]))
    else $error("global enable write lost");
endmodule : irq_flag_enable_controller

// file: irq_ctrl_pkg.sv
// irq_ctrl_pkg: register map, bit positions and source ids for the
// interrupt collection block.
// assumes a wishbone master with 32-bit words, one register per word.
package irq_ctrl_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_EDGE = 4'h0;
  localparam logic [3:0] OFS_CTL0 = 4'h4;
  localparam logic [3:0] OFS_CTL1 = 4'h8;
  localparam logic [3:0] OFS_CTL2 = 4'hC;
  localparam int unsigned NSRC = 9;
  // source ids in priority order, 0 highest
  localparam int unsigned SRC_EXT = 0;
  localparam int unsigned SRC_LOW = 1;
  localparam int unsigned SRC_SER = 2;
  localparam int unsigned SRC_CONV = 3;
  localparam int unsigned SRC_TMP = 4;
  localparam int unsigned SRC_TMA = 5;
  localparam int unsigned SRC_EEP = 6;
  localparam int unsigned SRC_TB0 = 7;
  localparam int unsigned SRC_TB1 = 8;
  // control 0 fields
  localparam int unsigned C0_GLOBAL = 0;
  localparam int unsigned C0_EXT_ON = 1;
  localparam int unsigned C0_SER_ON = 2;
  localparam int unsigned C0_LOW_ON = 3;
  localparam int unsigned C0_EXT_F = 4;
  localparam int unsigned C0_SER_F = 5;
  localparam int unsigned C0_LOW_F = 6;
  // control 1 fields
  localparam int unsigned C1_CONV_ON = 0;
  localparam int unsigned C1_EEP_ON = 1;
  localparam int unsigned C1_TMP_ON = 2;
  localparam int unsigned C1_TMA_ON = 3;
  localparam int unsigned C1_CONV_F = 4;
  localparam int unsigned C1_EEP_F = 5;
  localparam int unsigned C1_TMP_F = 6;
  localparam int unsigned C1_TMA_F = 7;
  // control 2 fields
  localparam int unsigned C2_TB0_ON = 0;
  localparam int unsigned C2_TB1_ON = 1;
  localparam int unsigned C2_TB0_F = 4;
  localparam int unsigned C2_TB1_F = 5;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [8:0] NSRC_RST = 9'h000;
endpackage : irq_ctrl_pkg

// file: core_model.sv
// core_model: cpu core side, takes an offered vector when allowed.
// assumes the controller holds its request level until it is taken.
`timescale 1ns/100ps
module core_model (
  input wire logic clk_in, // system clock
  input wire logic rst_in, // sync reset, active high
  input wire logic req_in, // request level from controller
  input wire logic [3:0] vec_in, // offered source id
  input wire logic accept_in, // bench lets the core take
  output logic take_out, // take pulse
  output logic [3:0] last_vec_out, // id of the last take
  output logic [7:0] taken_out // number of takes so far
);
  logic [3:0] last_vec_d;
  logic [7:0] taken_d;
  // no stall of its own: the request drops the cycle after, so one pulse
  assign take_out = req_in & accept_in;
  always_comb begin
    last_vec_d = take_out ? vec_in : last_vec_out;
    taken_d = taken_out + {7'h00, take_out};
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      last_vec_out <= 4'h0;
      taken_out <= 8'h00;
    end else begin
      last_vec_out <= last_vec_d;
      taken_out <= taken_d;
    end
  end
endmodule : core_model

// file: testbench.sv
// testbench: drives the irq block over wishbone and event lines.
// assumes one 10 MHz clock, sync reset and core_model as the core.
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0, vec, lvec;
  logic [3:0] wsel = 4'h1;
  logic [31:0] wdat = 32'h0000_0000, rdat, got;
  logic pin = 1'b0, full = 1'b0, accept = 1'b0, ack, take, req, wake;
  logic [8:1] ev = 8'h00;
  logic [7:0] ntk;
  int mismatches = 0, n_tests = 0, cycles = 0;
  // offset and flag bit per source id
  logic [3:0] ro [9] = '{4'h4, 4'h4, 4'h4, 4'h8, 4'h8, 4'h8, 4'h8,
    4'hC, 4'hC};
  int fb [9] = '{4, 6, 5, 4, 6, 7, 5, 4, 5};
  logic [7:0] rw [4] = '{8'h03, 8'h7F, 8'hFF, 8'h33};
  always #50 clk = ~clk;
  irq_flag_enable_controller i_irq_flag_enable_controller (.CLK_IN(clk),
    .RST_IN(rst), .WB_ADR_IN(adr), .WB_DAT_IN(wdat), .WB_SEL_IN(sel),
    .WB_WE_IN(we), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_DAT_OUT(rdat),
    .WB_ACK_OUT(ack), .EXT_PIN_IN(pin), .LOW_SUPPLY_EV_IN(ev[1]),
    .SERIAL_EV_IN(ev[2]), .CONVERTER_EV_IN(ev[3]), .EEPROM_EV_IN(ev[6]),
    .MATCH_P_EV_IN(ev[4]), .MATCH_A_EV_IN(ev[5]), .TICK0_EV_IN(ev[7]),
    .TICK1_EV_IN(ev[8]), .STACK_FULL_IN(full), .IRQ_TAKE_IN(take),
    .IRQ_REQ_OUT(req), .IRQ_VEC_OUT(vec), .WAKE_OUT(wake));
  core_model i_core_model (.clk_in(clk), .rst_in(rst), .req_in(req),
    .vec_in(vec), .accept_in(accept), .take_out(take),
    .last_vec_out(lvec), .taken_out(ntk));
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk_val
  task automatic chk_bit(input logic g, input logic e);
    chk_val({31'h0000_0000, g}, {31'h0000_0000, e});
  endtask : chk_bit
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= wsel;
    wdat <= {24'h00_0000, d};
    // bus outputs are read before this edge's updates land
    do @(posedge clk); while (ack !== 1'b1);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask : pause
  task automatic t_regs();
    for (int a = 0; a < 4; a++) begin
      wb(1'b0, 4'(4 * a), 8'h00);
      chk_val(got, 32'h0000_0000);
      wb(1'b1, 4'(4 * a), 8'hFF);
      wb(1'b0, 4'(4 * a), 8'h00);
      chk_val(got, {24'h00_0000, rw[a]});
      wb(1'b1, 4'(4 * a), 8'h00);
    end
    // a write with byte select 0 low must leave the register alone
    wsel = 4'h0;
    wb(1'b1, 4'h8, 8'hFF);
    wsel = 4'h1;
    wb(1'b0, 4'h8, 8'h00);
    chk_val(got, 32'h0000_0000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_events();
    for (int i = 1; i < 9; i++) begin
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
      pause(1);
      chk_bit(wake, 1'b1);
      wb(1'b0, ro[i], 8'h00);
      chk_val(got, 32'h0000_0001 << fb[i]);
      wb(1'b1, ro[i], 8'h00);
      pause(1);
      chk_bit(wake, 1'b0);
    end
    $display("test events done");
  endtask : t_events
  task automatic pin_to(input logic lvl, input logic e);
    @(posedge clk);
    pin <= lvl;
    pause(6);
    wb(1'b0, 4'h4, 8'h00);
    chk_val(got, e ? 32'h0000_0010 : 32'h0000_0000);
    wb(1'b1, 4'h4, 8'h00);
  endtask : pin_to
  task automatic t_edge();
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, 4'h0, 8'(m));
      pin_to(1'b1, m[0]);
      pin_to(1'b0, m[1]);
    end
    $display("test edge done");
  endtask : t_edge
  task automatic t_gate();
    @(posedge clk);
    ev[7] <= 1'b1;
    @(posedge clk);
    ev[7] <= 1'b0;
    wb(1'b1, 4'hC, 8'h11);
    pause(2);
    chk_bit(req, 1'b0);
    wb(1'b1, 4'h4, 8'h01);
    pause(2);
    chk_bit(req, 1'b1);
    chk_val({28'h000_0000, vec}, 32'h0000_0007);
    wb(1'b1, 4'hC, 8'h10);
    pause(2);
    chk_bit(req, 1'b0);
    chk_bit(wake, 1'b1);
    wb(1'b1, 4'hC, 8'h11);
    full <= 1'b1;
    pause(3);
    chk_bit(req, 1'b0);
    full <= 1'b0;
    pause(2);
    chk_bit(req, 1'b1);
    wb(1'b1, 4'hC, 8'h00);
    wb(1'b1, 4'h4, 8'h00);
    $display("test gate done");
  endtask : t_gate
  task automatic t_prio();
    logic [7:0] c0;
    wb(1'b1, 4'h8, 8'hFF);
    wb(1'b1, 4'hC, 8'h33);
    accept <= 1'b1;
    wb(1'b1, 4'h4, 8'h7F);
    for (int k = 0; k < 9; k++) begin
      while (ntk != 8'(k + 1)) @(posedge clk);
      chk_val({28'h000_0000, lvec}, 32'(k));
      c0 = {1'b0, k < 1, k < 2, 5'h0E};
      wb(1'b0, 4'h4, 8'h00);
      chk_val(got, {24'h00_0000, c0});
      wb(1'b1, 4'h4, c0 | 8'h01);
    end
    accept <= 1'b0;
    wb(1'b0, 4'h8, 8'h00);
    chk_val(got, 32'h0000_000F);
    $display("test prio done");
  endtask : t_prio
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  // whole run is well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    pause(10);
    rst <= 1'b0;
    t_regs();
    t_events();
    t_edge();
    t_gate();
    t_prio();
    conclude();
  end
endmodule : testbench
